/* File: include/pdm_pkg.sv */
// constants for the port d/e pin function mux
package pdm_pkg;
    localparam int PUD_DSEL_BIT = 9;
    localparam int PUD_CS2_BIT = 0;
    localparam int PUD_CS3_BIT = 1;
    localparam int PUE_TX_BIT = 0;
    localparam int PUE_RX_BIT = 1;
    localparam int PER_CS2_BIT = 0;
    localparam int PER_CS3_BIT = 1;
    localparam int GPS_CS2_BIT = 4;
    localparam int GPS_CS3_BIT = 5;
    localparam int PER_E_TX_BIT = 0;
    localparam int PER_E_RX_BIT = 1;
    localparam logic [15:0] PORT_D_PULLUP_RST = 16'hFFFF;
    localparam logic [15:0] PORT_E_PULLUP_RST = 16'hFFFF;
    localparam logic [15:0] PORT_D_PER_RST = 16'h0000;
    localparam logic [15:0] SYS_FSEL_RST = 16'h0000;
    localparam logic [1:0] PORT_E_PER_RST = 2'h3;
    localparam logic BUS_DRIVE_RST = 1'b0;
    localparam logic [1:0] CS_REGION_RST = 2'h0;
endpackage

/* File: design/pdm_pad.sv */
// one shared pad: gpio or peripheral, pull-up and open-drain selection
`timescale 1ns/10ps
module pdm_pad (
    input wire logic gpio_mode,
    input wire logic gpio_out,
    input wire logic gpio_dir_out,
    input wire logic per_out,
    input wire logic per_oe,
    input wire logic per_od,
    input wire logic pull_en,
    output logic pad_out,
    output logic pad_oe,
    output logic pad_pull
);
    always_comb begin
        if (gpio_mode) begin
            pad_out = gpio_out;
            pad_oe = gpio_dir_out;
        end else if (per_od) begin
            pad_out = 1'b0;
            pad_oe = per_oe & ~per_out;
        end else begin
            pad_out = per_out;
            pad_oe = per_oe;
        end
        pad_pull = pull_en;
    end
endmodule

/* File: design/pdm_top.sv */
// pin function mux for data select, chip selects two/three, second can and serial port zero
`timescale 1ns/10ps
module pdm_top #(
    parameter int NUM_GPIO = 5
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    // configuration written by software
    input wire logic [15:0] port_d_peripheral_enable,
    input wire logic [1:0] port_e_peripheral_enable,
    input wire logic [15:0] system_function_select,
    input wire logic [15:0] port_d_pullup_enable,
    input wire logic [15:0] port_e_pullup_enable,
    input wire logic bus_drive_when_idle,
    input wire logic cfg_write,
    input wire logic [1:0] cs1_region_sel,
    input wire logic [1:0] cs2_region_sel,
    input wire logic [1:0] cs3_region_sel,
    // gpio: index 0 line_9, 1 d line_0, 2 d line_1, 3 e line_0, 4 e line_1
    input wire logic [NUM_GPIO-1:0] gpio_out,
    input wire logic [NUM_GPIO-1:0] gpio_dir_out,
    // memory interface, peripheral transmit lines and pad inputs
    input wire logic bus_active,
    input wire logic [1:0] access_region,
    input wire logic serial0_transmit,
    input wire logic second_can_transmit,
    input wire logic [NUM_GPIO-1:0] pad_in,
    output logic [NUM_GPIO-1:0] pad_out,
    output logic [NUM_GPIO-1:0] pad_oe,
    output logic [NUM_GPIO-1:0] pad_pull,
    output logic [NUM_GPIO-1:0] gpio_in,
    output logic second_can_receive,
    output logic serial0_receive,
    output logic chip_sel_three_in_use
);
    ////////////////////////////////////////////////////////////////////////////
    // configuration registers, loaded on cfg_write
    logic [15:0] per_d_r, per_d_nxt, fsel_r, fsel_nxt, pud_r, pud_nxt, pue_r, pue_nxt;
    logic [1:0] per_e_r, per_e_nxt, rg1_r, rg1_nxt, rg2_r, rg2_nxt, rg3_r, rg3_nxt;
    logic drv_r, drv_nxt;

    always_comb begin
        per_d_nxt = per_d_r;
        per_e_nxt = per_e_r;
        fsel_nxt = fsel_r;
        pud_nxt = pud_r;
        pue_nxt = pue_r;
        drv_nxt = drv_r;
        rg1_nxt = rg1_r;
        rg2_nxt = rg2_r;
        rg3_nxt = rg3_r;
        if (cfg_write) begin
            per_d_nxt = port_d_peripheral_enable;
            per_e_nxt = port_e_peripheral_enable;
            fsel_nxt = system_function_select;
            pud_nxt = port_d_pullup_enable;
            pue_nxt = port_e_pullup_enable;
            drv_nxt = bus_drive_when_idle;
            rg1_nxt = cs1_region_sel;
            rg2_nxt = cs2_region_sel;
            rg3_nxt = cs3_region_sel;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            per_d_r <= pdm_pkg::PORT_D_PER_RST;
            per_e_r <= pdm_pkg::PORT_E_PER_RST;
            fsel_r <= pdm_pkg::SYS_FSEL_RST;
            pud_r <= pdm_pkg::PORT_D_PULLUP_RST;
            pue_r <= pdm_pkg::PORT_E_PULLUP_RST;
            drv_r <= pdm_pkg::BUS_DRIVE_RST;
            rg1_r <= pdm_pkg::CS_REGION_RST;
            rg2_r <= pdm_pkg::CS_REGION_RST;
            rg3_r <= pdm_pkg::CS_REGION_RST;
        end else begin
            per_d_r <= per_d_nxt;
            per_e_r <= per_e_nxt;
            fsel_r <= fsel_nxt;
            pud_r <= pud_nxt;
            pue_r <= pue_nxt;
            drv_r <= drv_nxt;
            rg1_r <= rg1_nxt;
            rg2_r <= rg2_nxt;
            rg3_r <= rg3_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // chip select decode; region 0 on cs1 is the data space at reset
    logic cs1_n, cs2_n, cs3_n;
    assign cs1_n = ~(bus_active && access_region == rg1_r);
    assign cs2_n = ~(bus_active && access_region == rg2_r);
    assign cs3_n = ~(bus_active && access_region == rg3_r);

    // per-pad modes; fsel bit clear picks chip select, set picks can
    logic [NUM_GPIO-1:0] gmode, p_out, p_oe, p_od, pull;
    always_comb begin
        gmode = '1;
        gmode[1] = ~per_d_r[pdm_pkg::PER_CS2_BIT];
        gmode[2] = ~per_d_r[pdm_pkg::PER_CS3_BIT];
        gmode[3] = ~per_e_r[pdm_pkg::PER_E_TX_BIT];
        gmode[4] = ~per_e_r[pdm_pkg::PER_E_RX_BIT];
        // d line 9 gpio use is not offered, so the data select pin is always a memory pin
        gmode[0] = 1'b0;
        // idle chip selects float unless bus drive is set
        p_oe = '0;
        p_od = '0;
        p_out = '1;
        p_out[0] = cs1_n;
        p_oe[0] = bus_active | drv_r;
        if (fsel_r[pdm_pkg::GPS_CS2_BIT]) begin
            p_out[1] = second_can_transmit;
            p_oe[1] = 1'b1;
            p_od[1] = 1'b1;
        end else begin
            p_out[1] = cs2_n;
            p_oe[1] = bus_active | drv_r;
        end
        p_out[2] = cs3_n;
        p_oe[2] = ~fsel_r[pdm_pkg::GPS_CS3_BIT] & (bus_active | drv_r);
        p_out[3] = serial0_transmit;
        p_oe[3] = 1'b1;
        pull[0] = pud_r[pdm_pkg::PUD_DSEL_BIT];
        pull[1] = pud_r[pdm_pkg::PUD_CS2_BIT];
        pull[2] = pud_r[pdm_pkg::PUD_CS3_BIT];
        pull[3] = pue_r[pdm_pkg::PUE_TX_BIT];
        pull[4] = pue_r[pdm_pkg::PUE_RX_BIT];
    end

    logic [NUM_GPIO-1:0] o_c, oe_c, pl_c;
    genvar gi;
    generate
        for (gi = 0; gi < NUM_GPIO; gi++) begin : g_pad
            pdm_pad u_pad (
                .gpio_mode(gmode[gi]),
                .gpio_out(gpio_out[gi]),
                .gpio_dir_out(gpio_dir_out[gi]),
                .per_out(p_out[gi]),
                .per_oe(p_oe[gi]),
                .per_od(p_od[gi]),
                .pull_en(pull[gi]),
                .pad_out(o_c[gi]),
                .pad_oe(oe_c[gi]),
                .pad_pull(pl_c[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // registered outputs; inputs to idle peripherals rest at recessive high
    logic can_rx_nxt, sci_rx_nxt, cs3_use_nxt;
    logic [NUM_GPIO-1:0] gin_nxt;
    always_comb begin
        can_rx_nxt = (~gmode[2] & fsel_r[pdm_pkg::GPS_CS3_BIT]) ? pad_in[2] : 1'b1;
        sci_rx_nxt = gmode[4] ? 1'b1 : pad_in[4];
        gin_nxt = pad_in & gmode;
        cs3_use_nxt = ~gmode[2] & ~fsel_r[pdm_pkg::GPS_CS3_BIT];
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pad_out <= '1;
            pad_oe <= '0;
            pad_pull <= '1;
            gpio_in <= '0;
            second_can_receive <= 1'b1;
            serial0_receive <= 1'b1;
            chip_sel_three_in_use <= 1'b0;
        end else begin
            pad_out <= o_c;
            pad_oe <= oe_c;
            pad_pull <= pl_c;
            gpio_in <= gin_nxt;
            second_can_receive <= can_rx_nxt;
            serial0_receive <= sci_rx_nxt;
            chip_sel_three_in_use <= cs3_use_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    sequence s_data_access;
        bus_active && access_region == rg1_r;
    endsequence

    a_dsel_low_access: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_data_access |=> !pad_out[0] && pad_oe[0]) else $error("data select not low");
    a_idle_float: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !bus_active && !drv_r |=> !pad_oe[0]) else $error("idle select driven");
    a_gpio_cut_can: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !per_d_r[pdm_pkg::PER_CS3_BIT] |=> second_can_receive) else $error("can rx leak");
    a_cs2_gpio_dir: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !per_d_r[pdm_pkg::PER_CS2_BIT] |=> pad_oe[1] == $past(gpio_dir_out[1]))
        else $error("cs2 pin dir wrong");
    a_pull_d9: assert property (@(posedge clk_sys) disable iff (!rst_n)
        1'b1 |=> pad_pull[0] == $past(pud_r[pdm_pkg::PUD_DSEL_BIT])) else $error("pull d9");
    a_pull_e0: assert property (@(posedge clk_sys) disable iff (!rst_n)
        1'b1 |=> pad_pull[3] == $past(pue_r[pdm_pkg::PUE_TX_BIT])) else $error("pull e0");
    a_tx_default: assert property (@(posedge clk_sys) disable iff (!rst_n)
        per_e_r[pdm_pkg::PER_E_TX_BIT] |=> pad_out[3] == $past(serial0_transmit))
        else $error("tx not serial");
    a_cs3_region: assert property (@(posedge clk_sys) disable iff (!rst_n)
        per_d_r[pdm_pkg::PER_CS3_BIT] && !fsel_r[pdm_pkg::GPS_CS3_BIT] && bus_active
        && access_region == rg3_r |=> !pad_out[2]) else $error("cs3 not asserted");
endmodule

/* File: bench/pdm_ext_world.sv */
// far side of the pads: memories, can transceiver and serial line resolving each wire
`timescale 1ns/10ps
module pdm_ext_world (
    input wire logic clk_sys,
    input wire logic [4:0] pad_out,
    input wire logic [4:0] pad_oe,
    input wire logic [4:0] pad_pull,
    input wire logic [4:0] ext_en,
    input wire logic [4:0] ext_val,
    output logic [4:0] pad_in
);
    logic tog_r = 1'b0;
    // an undriven wire with no pull-up must not look settled
    always @(posedge clk_sys) tog_r <= ~tog_r;
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            pad_in[i] = pad_oe[i] ? pad_out[i] : ext_en[i] ? ext_val[i] :
                        pad_pull[i] ? 1'b1 : tog_r;
        end
    end
endmodule

/* File: bench/tb.sv */
// self-checking bench for the pin function mux
`timescale 1ns/10ps
module tb;
    logic clk_sys, rst_n, cfg_write, bus_drive_when_idle, bus_active, s_drv;
    logic serial0_transmit, second_can_transmit, second_can_receive, serial0_receive;
    logic chip_sel_three_in_use;
    logic [15:0] port_d_peripheral_enable, system_function_select;
    logic [15:0] port_d_pullup_enable, port_e_pullup_enable, s_fsel, s_pud, s_pue, s_perd;
    logic [1:0] port_e_peripheral_enable, s_pere, cs1_region_sel, cs2_region_sel;
    logic [1:0] cs3_region_sel, access_region, s_r1, s_r2, s_r3;
    logic [4:0] gpio_out, gpio_dir_out, pad_in, pad_out, pad_oe, pad_pull, gpio_in;
    logic [4:0] ext_en, ext_val;
    logic [31:0] seed;
    int miscompares, comparisons;
    pdm_top u_pdm_top (.clk_sys(clk_sys), .rst_n(rst_n),
        .port_d_peripheral_enable(port_d_peripheral_enable),
        .port_e_peripheral_enable(port_e_peripheral_enable),
        .system_function_select(system_function_select),
        .port_d_pullup_enable(port_d_pullup_enable), .port_e_pullup_enable(port_e_pullup_enable),
        .bus_drive_when_idle(bus_drive_when_idle), .cfg_write(cfg_write),
        .cs1_region_sel(cs1_region_sel), .cs2_region_sel(cs2_region_sel),
        .cs3_region_sel(cs3_region_sel), .gpio_out(gpio_out), .gpio_dir_out(gpio_dir_out),
        .bus_active(bus_active), .access_region(access_region),
        .serial0_transmit(serial0_transmit), .second_can_transmit(second_can_transmit),
        .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull(pad_pull),
        .gpio_in(gpio_in), .second_can_receive(second_can_receive),
        .serial0_receive(serial0_receive), .chip_sel_three_in_use(chip_sel_three_in_use));
    pdm_ext_world u_pdm_ext_world (.clk_sys(clk_sys), .pad_out(pad_out), .pad_oe(pad_oe),
        .pad_pull(pad_pull), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
    endfunction
    function automatic logic cs_lvl(input logic [1:0] r);
        return !(bus_active && access_region == r);
    endfunction
    task automatic check(input logic [4:0] seen, input logic [4:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic check_all();
        logic [4:0] eo, ee, pl, gm, st;
        logic idl;
        idl = bus_active | s_drv;
        gm = {~s_pere[1], ~s_pere[0], ~s_perd[1], ~s_perd[0], 1'b0};
        pl = {s_pue[pdm_pkg::PUE_RX_BIT], s_pue[pdm_pkg::PUE_TX_BIT], s_pud[pdm_pkg::PUD_CS3_BIT],
              s_pud[pdm_pkg::PUD_CS2_BIT], s_pud[pdm_pkg::PUD_DSEL_BIT]};
        eo = gpio_out;
        ee = gpio_dir_out;
        eo[0] = cs_lvl(s_r1);
        ee[0] = idl;
        if (s_perd[0]) begin
            eo[1] = s_fsel[4] ? 1'b0 : cs_lvl(s_r2);
            ee[1] = s_fsel[4] ? !second_can_transmit : idl;
        end
        if (s_perd[1]) begin
            eo[2] = cs_lvl(s_r3);
            ee[2] = s_fsel[5] ? 1'b0 : idl;
        end
        if (s_pere[0]) begin
            eo[3] = serial0_transmit;
            ee[3] = 1'b1;
        end
        if (s_pere[1]) ee[4] = 1'b0;
        st = ee | ext_en | pl;
        check(pad_oe, ee);
        check(pad_out & ee, eo & ee);
        check(pad_pull, pl);
        check(gpio_in & st, pad_in & gm & st);
        // a floating receive pin has no defined level, so both sides are masked alike
        check({2'h0, chip_sel_three_in_use, second_can_receive | ~st[2],
               serial0_receive | ~st[4]},
              {2'h0, s_perd[1] & ~s_fsel[5],
               ((s_perd[1] & s_fsel[5]) ? pad_in[2] : 1'b1) | ~st[2],
               (s_pere[1] ? pad_in[4] : 1'b1) | ~st[4]});
    endtask
    task automatic reset_checks();
        check(pad_oe, 5'h00);
        check(pad_pull & gpio_in, 5'h00);
        check(pad_pull, 5'h1F);
        check({2'h0, chip_sel_three_in_use, second_can_receive, serial0_receive}, 5'h03);
        // the design's configuration is back at its defaults, so the shadow follows
        {s_perd, s_pere, s_fsel} = {pdm_pkg::PORT_D_PER_RST, pdm_pkg::PORT_E_PER_RST,
                                    pdm_pkg::SYS_FSEL_RST};
        {s_pud, s_pue, s_drv} = {pdm_pkg::PORT_D_PULLUP_RST, pdm_pkg::PORT_E_PULLUP_RST,
                                 pdm_pkg::BUS_DRIVE_RST};
        {s_r1, s_r2, s_r3} = {3{pdm_pkg::CS_REGION_RST}};
    endtask
    task automatic print_verdict();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] q;
        {port_d_peripheral_enable, system_function_select, port_e_peripheral_enable} = '0;
        {cs1_region_sel, cs2_region_sel, cs3_region_sel, access_region} = '0;
        {cfg_write, bus_drive_when_idle, bus_active, serial0_transmit} = '0;
        {second_can_transmit, gpio_out, gpio_dir_out, ext_en, ext_val} = '0;
        port_d_pullup_enable = 16'hFFFF;
        port_e_pullup_enable = 16'hFFFF;
        seed = 32'hf3410dcc;
        miscompares = 0;
        comparisons = 0;
        rst_n = 1'b0;
        repeat (20) @(posedge clk_sys);
        @(negedge clk_sys);
        reset_checks();
        rst_n = 1'b1;
        for (int i = 0; i < 150; i++) begin
            if (i == 75) begin
                // second reset in mid-run: every pin must fall back to its reset function
                rst_n = 1'b0;
                repeat (2) @(negedge clk_sys);
                reset_checks();
                rst_n = 1'b1;
            end
            seed = lfsr(seed);
            q = seed;
            port_d_peripheral_enable = {14'h0, q[1:0]};
            port_e_peripheral_enable = q[3:2];
            system_function_select = {10'h0, q[5:4], 4'h0};
            bus_drive_when_idle = q[6];
            cfg_write = (i > 0) & q[7];
            {cs1_region_sel, cs2_region_sel, cs3_region_sel} = q[13:8];
            {bus_active, access_region, serial0_transmit, second_can_transmit} = q[18:14];
            {gpio_out, gpio_dir_out} = q[28:19];
            seed = lfsr(seed);
            {port_d_pullup_enable, port_e_pullup_enable} = seed;
            seed = lfsr(seed);
            {ext_en, ext_val} = seed[9:0] & {~seed[10], 9'h1FF};
            if (i == 1 || i == 2) begin
                {cfg_write, port_d_peripheral_enable, system_function_select} = {17'h10003, 16'h0};
                {bus_active, bus_drive_when_idle} = {1'b0, i == 2};
            end
            if (cfg_write) begin
                {s_perd, s_pere, s_fsel, s_drv} = {port_d_peripheral_enable,
                    port_e_peripheral_enable, system_function_select, bus_drive_when_idle};
                {s_pud, s_pue} = {port_d_pullup_enable, port_e_pullup_enable};
                {s_r1, s_r2, s_r3} = {cs1_region_sel, cs2_region_sel, cs3_region_sel};
            end
            repeat (3) @(negedge clk_sys);
            check_all();
            $display("test %0d done", i);
            @(negedge clk_sys);
        end
        print_verdict();
    end
endmodule
